// file: core/eswc_pkg.sv
// Constants, opcodes and carrier types for the EEPROM select/commit block.
package eswc_pkg;

   // Core clock rate and the self-timed write cycle length.
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned WRITE_TIME_MS = 5;
   // Longest time, so the cycle count rounds down.
   localparam int unsigned WRITE_CYCLES = (CLK_HZ / 1000) * WRITE_TIME_MS;

   // Instruction bytes that this block has to recognise.
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] OP_SET_PERMIT = 8'h06;
   localparam logic [7:0] OP_CLR_PERMIT = 8'h04;

   // Frame lengths in serial bits.
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned WRITE_MIN_BITS = 32;

   // Status byte layout, the rest reads as zero.
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_PERMIT_BIT = 1;

   // Select-line states of the core domain.
   typedef enum logic [1:0] {
      ESWC_ST_STANDBY = 2'b00,
      ESWC_ST_SEL = 2'b01,
      ESWC_ST_BUSY = 2'b10
   } eswc_state_e;

   // Summary of the last frame, built on the serial clock.
   typedef struct packed {
      logic write_ok;
      logic set_ok;
      logic clr_ok;
   } eswc_frame_s;

   // Core state carried into the serial clock domain.
   typedef struct packed {
      logic armed;
      logic busy;
      logic permit;
   } eswc_stat_s;

endpackage

// file: core/eswc_select_ctrl.sv
// Select, standby, output tri-state and write commit of a serial EEPROM.
`timescale 1ns/1ns

// Functional notes
// (RULE1) A low select level selects the device and only then are sequences accepted.
// (RULE2) A high select level deselects the device into standby unless a write cycle runs.
// (RULE3) A started write cycle runs to its end whatever the select line does.
// (RULE4) Select raised during a write cycle means standby right after the cycle ends.
// (RULE5) The serial output floats as soon as the device is deselected.
// (RULE6) A select rising edge after a complete valid write sequence starts the write cycle.
// (RULE7) After power-up no sequence is taken until a falling select edge has been seen.
// (RULE8) Every write cycle ends within 5 ms of its start.
// (RULE9) The write permit latch clears itself when a write cycle ends.
// (RULE10) During a write cycle array reads are refused while status reads still work.
// (RULE11) Deselection throws away any partial sequence so the next one starts fresh.
module eswc_select_ctrl
   import eswc_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES,
   parameter int unsigned CNT_W = 16
) (
   // Core clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Serial link from the host.
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   // Device state towards the rest of the chip.
   output logic selected_o,
   output logic standby_o,
   output logic write_busy_flag,
   output logic write_permit_latch,
   output logic write_start_o,
   output logic array_read_en_o
);

   // Parameters that the counters cannot serve are refused.
   initial begin
      if (WRITE_CYCLES_P < 1 || CNT_W < 6 || CNT_W > 31) begin
         $error("eswc_select_ctrl: bad parameter value");
      end
   end

   // True when the frame held exactly one byte of the given opcode.
   function automatic logic fn_op_byte(input logic [7:0] op,
                                       input logic [CNT_W-1:0] cnt,
                                       input logic [7:0] opc);
      fn_op_byte = (op == opc) && (cnt == CNT_W'(BYTE_BITS));
   endfunction

   // Status byte as shifted out, built from the synchronised flags.
   function automatic logic [7:0] fn_stat_byte(input eswc_stat_s st);
      fn_stat_byte = 8'h00;
      fn_stat_byte[STAT_BUSY_BIT] = st.busy;
      fn_stat_byte[STAT_PERMIT_BIT] = st.permit;
   endfunction

   // ---------------- Core clock domain ----------------
   logic cs_s1_r, cs_s2_r, cs_d_r;
   logic tog_s1_r, tog_s2_r, seen_tog_r, seen_tog_nxt;
   eswc_frame_s frm_s1_r, frm_s2_r;
   eswc_state_e state_r, state_nxt;
   logic armed_r, armed_nxt, permit_r, permit_nxt;
   logic [31:0] timer_r, timer_nxt;
   logic cs_fall, cs_rise, frame_end, commit;
   logic sel_nxt, stby_nxt, start_nxt;
   // Signals from the serial clock domain.
   logic tog_r;
   eswc_frame_s frm_r;

   // Select edges after the two-stage synchroniser.
   assign cs_fall = cs_d_r & ~cs_s2_r;
   assign cs_rise = ~cs_d_r & cs_s2_r;
   // A frame counts only if it carried clocks not yet consumed.
   assign frame_end = cs_rise && armed_r && (state_r == ESWC_ST_SEL)
                      && (tog_s2_r != seen_tog_r); // RULE11
   assign commit = frame_end && frm_s2_r.write_ok && permit_r; // RULE6

   // Next state of the select machine, the write timer and the latches.
   always_comb begin
      state_nxt = state_r;
      timer_nxt = timer_r;
      seen_tog_nxt = seen_tog_r;
      armed_nxt = armed_r | cs_fall; // RULE7
      permit_nxt = permit_r;
      start_nxt = 1'b0;
      // Every select rise consumes the frame's clocks, so a frame that was
      // ignored is never counted again at the next select rise.
      if (cs_rise) begin
         seen_tog_nxt = tog_s2_r; // RULE11
      end
      if (frame_end) begin
         if (frm_s2_r.set_ok) begin
            permit_nxt = 1'b1;
         end
         if (frm_s2_r.clr_ok) begin
            permit_nxt = 1'b0;
         end
      end
      unique case (state_r)
         ESWC_ST_STANDBY: begin
            if (cs_fall) begin
               state_nxt = ESWC_ST_SEL; // RULE1
            end
         end
         ESWC_ST_SEL: begin
            if (commit) begin
               state_nxt = ESWC_ST_BUSY;
               timer_nxt = 32'(WRITE_CYCLES_P - 1); // RULE8
               start_nxt = 1'b1;
            end else if (cs_rise) begin
               state_nxt = ESWC_ST_STANDBY; // RULE2
            end
         end
         ESWC_ST_BUSY: begin
            // Frames seen while busy are consumed so they never commit.
            seen_tog_nxt = tog_s2_r;
            if (timer_r == 32'h0) begin
               permit_nxt = 1'b0; // RULE9
               state_nxt = cs_s2_r ? ESWC_ST_STANDBY : ESWC_ST_SEL; // RULE4
            end else begin
               timer_nxt = timer_r - 32'h1; // RULE3
            end
         end
         default: begin
            state_nxt = ESWC_ST_STANDBY;
         end
      endcase
      sel_nxt = armed_nxt && !cs_s2_r;
      stby_nxt = (state_nxt == ESWC_ST_STANDBY);
   end

   // The select synchroniser runs through reset, so a select held low
   // across reset release is not mistaken for a falling edge.
   always_ff @(posedge clk) begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
   end

   // Registers of the core domain, synchronous reset.
   always_ff @(posedge clk) begin
      if (reset) begin
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         frm_s1_r <= '0;
         frm_s2_r <= '0;
         seen_tog_r <= 1'b0;
         state_r <= ESWC_ST_STANDBY;
         timer_r <= 32'h0;
         armed_r <= 1'b0;
         permit_r <= 1'b0;
         selected_o <= 1'b0;
         standby_o <= 1'b1;
         write_busy_flag <= 1'b0;
         write_permit_latch <= 1'b0;
         write_start_o <= 1'b0;
      end else begin
         tog_s1_r <= tog_r;
         tog_s2_r <= tog_s1_r;
         frm_s1_r <= frm_r;
         frm_s2_r <= frm_s1_r;
         seen_tog_r <= seen_tog_nxt;
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         armed_r <= armed_nxt;
         permit_r <= permit_nxt;
         selected_o <= sel_nxt;
         standby_o <= stby_nxt;
         write_busy_flag <= (state_nxt == ESWC_ST_BUSY);
         write_permit_latch <= permit_nxt;
         write_start_o <= start_nxt;
      end
   end

   // ---------------- Serial clock domain ----------------
   // The host clock stops while deselected, so frame-end work is left to
   // the core domain and only the frame start is seen here.
   logic fresh_clr;
   logic fresh_r, rd_en_r, rd_en_nxt, tog_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [7:0] op_r, op_nxt;
   eswc_frame_s frm_nxt;
   eswc_stat_s stat_k1_r, stat_k2_r, stat_src;
   logic so_nxt, so_oe_nxt;
   logic [7:0] stat_byte;

   assign fresh_clr = reset | cs_n; // RULE5
   assign stat_src = '{armed: armed_r, busy: write_busy_flag,
                       permit: permit_r};

   // Bit counting, opcode capture and frame summary on the rising edge.
   always_comb begin
      rd_en_nxt = rd_en_r;
      tog_nxt = tog_r;
      if (fresh_r) begin
         cnt_nxt = CNT_W'(1); // RULE11
         op_nxt = {7'h00, si};
         tog_nxt = ~tog_r;
      end else begin
         cnt_nxt = (&cnt_r) ? cnt_r : cnt_r + CNT_W'(1);
         op_nxt = (cnt_r < CNT_W'(BYTE_BITS)) ? {op_r[6:0], si} : op_r;
      end
      if (cnt_nxt == CNT_W'(BYTE_BITS) && op_nxt == OP_READ) begin
         rd_en_nxt = stat_k2_r.armed && !stat_k2_r.busy; // RULE10
      end
      frm_nxt.write_ok = (op_nxt == OP_WRITE)
                         && (cnt_nxt >= CNT_W'(WRITE_MIN_BITS))
                         && (cnt_nxt[2:0] == 3'h0); // RULE6
      frm_nxt.set_ok = fn_op_byte(op_nxt, cnt_nxt, OP_SET_PERMIT);
      frm_nxt.clr_ok = fn_op_byte(op_nxt, cnt_nxt, OP_CLR_PERMIT);
   end

   // Registers cleared by deselection: a new frame starts from scratch.
   always_ff @(posedge sck or posedge fresh_clr) begin
      if (fresh_clr) begin
         fresh_r <= 1'b1;
         rd_en_r <= 1'b0;
      end else begin
         fresh_r <= 1'b0;
         rd_en_r <= rd_en_nxt;
      end
   end

   // Registers that must outlive the frame for the core domain to read.
   always_ff @(posedge sck or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
         op_r <= 8'h00;
         frm_r <= '0;
         tog_r <= 1'b0;
         stat_k1_r <= '0;
         stat_k2_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         op_r <= op_nxt;
         frm_r <= frm_nxt;
         tog_r <= tog_nxt;
         stat_k1_r <= stat_src;
         stat_k2_r <= stat_k1_r;
      end
   end

   // Status byte driven MSB first after the falling edge; only status
   // reads drive the pin here, so a busy part never returns array data.
   always_comb begin
      so_oe_nxt = stat_k2_r.armed && (op_r == OP_STATUS)
                  && (cnt_r >= CNT_W'(BYTE_BITS));
      stat_byte = fn_stat_byte(stat_k2_r);
      so_nxt = stat_byte[3'h7 - cnt_r[2:0]];
   end

   // Output flops float the pin the moment select goes high.
   always_ff @(negedge sck or posedge fresh_clr) begin
      if (fresh_clr) begin
         so_o <= 1'b0;
         so_oe <= 1'b0; // RULE5
      end else begin
         so_o <= so_nxt;
         so_oe <= so_oe_nxt;
      end
   end

   assign array_read_en_o = rd_en_r;

   // ---------------- Checks ----------------
   logic [31:0] busy_age_r;
   // Counts cycles spent busy, read only by the checks.
   always_ff @(posedge clk) begin
      if (reset || state_r != ESWC_ST_BUSY) begin
         busy_age_r <= 32'h0;
      end else begin
         busy_age_r <= busy_age_r + 32'h1;
      end
   end

   property p_sel_low;
      @(posedge clk) disable iff (reset)
      selected_o |-> $past(!cs_s2_r) && $past(armed_nxt);
   endproperty
   a_sel_low: assert property (p_sel_low) // RULE1
      else $error("selected without low select");

   property p_deselect;
      @(posedge clk) disable iff (reset)
      (state_r == ESWC_ST_SEL && cs_rise && !commit)
      |=> standby_o && !selected_o;
   endproperty
   a_deselect: assert property (p_deselect) // RULE2
      else $error("no standby after deselect");

   property p_run_on;
      @(posedge clk) disable iff (reset)
      (state_r == ESWC_ST_BUSY && timer_r != 32'h0)
      |=> write_busy_flag && timer_r == $past(timer_r) - 32'h1;
   endproperty
   a_run_on: assert property (p_run_on) // RULE3
      else $error("write cycle cut short");

   property p_late_standby;
      @(posedge clk) disable iff (reset)
      (state_r == ESWC_ST_BUSY && timer_r == 32'h0 && cs_s2_r)
      |=> standby_o && !write_busy_flag;
   endproperty
   a_late_standby: assert property (p_late_standby) // RULE4
      else $error("no standby after write cycle");

   property p_float;
      @(posedge clk) disable iff (reset)
      cs_s1_r && cs_s2_r |-> !so_oe;
   endproperty
   a_float: assert property (p_float) // RULE5
      else $error("output driven while deselected");

   property p_commit;
      @(posedge clk) disable iff (reset)
      write_start_o |-> $past(cs_rise) && write_busy_flag
                        && $past(frm_s2_r.write_ok);
   endproperty
   a_commit: assert property (p_commit) // RULE6
      else $error("write start without valid commit");

   property p_armed;
      @(posedge clk) disable iff (reset)
      !armed_r |-> state_r == ESWC_ST_STANDBY ##1 !write_start_o;
   endproperty
   a_armed: assert property (p_armed) // RULE7
      else $error("sequence taken before first select fall");

   property p_limit;
      @(posedge clk) disable iff (reset)
      state_r == ESWC_ST_BUSY |-> busy_age_r < 32'(WRITE_CYCLES_P);
   endproperty
   a_limit: assert property (p_limit) // RULE8
      else $error("write cycle too long");

   property p_permit_clr;
      @(posedge clk) disable iff (reset)
      $fell(write_busy_flag) |-> !write_permit_latch;
   endproperty
   a_permit_clr: assert property (p_permit_clr) // RULE9
      else $error("permit latch kept after write");

   property p_no_array;
      @(posedge sck) disable iff (reset)
      rd_en_r && !$past(rd_en_r) |-> !$past(stat_k2_r.busy);
   endproperty
   a_no_array: assert property (p_no_array) // RULE10
      else $error("array read granted while busy");

   property p_fresh;
      @(posedge sck) disable iff (fresh_clr)
      fresh_r |=> cnt_r == CNT_W'(1);
   endproperty
   a_fresh: assert property (p_fresh) // RULE11
      else $error("frame did not restart count");

   c_commit: cover property (@(posedge clk) disable iff (reset)
      write_start_o);
   c_late: cover property (@(posedge clk) disable iff (reset)
      write_busy_flag && cs_s2_r ##1 !write_busy_flag);
   c_status: cover property (@(posedge sck) disable iff (reset)
      so_oe_nxt && stat_k2_r.busy);

endmodule

// file: verification/eswc_host_model.sv
// Host serial master model that drives select, serial clock and data in.
`timescale 1ns/1ns

module eswc_host_model (
   // Link towards the device.
   output logic sck,
   output logic cs_n,
   output logic si,
   // Answers from the device.
   input wire logic so_o,
   input wire logic so_oe,
   input wire logic array_read_en_o
);

   // Select starts low as at power-up, so the first frame has no fall.
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      si = 1'b0;
   end

   // One frame of n bits, MSB first; the serial clock runs only inside it.
   // Bits are sampled by the device on the rising edge, so si moves while
   // the clock is low; the output is taken on our rising edge.
   task automatic frame(input logic [31:0] d, input int n,
                        output logic [7:0] rx, output logic gr);
      rx = 8'h00;
      cs_n = 1'b0;
      #43;
      for (int i = n - 1; i >= 0; i--) begin
         si = d[i];
         #8 sck = 1'b1;
         if (so_oe === 1'b1) begin
            rx = {rx[6:0], so_o};
         end
         #7 sck = 1'b0;
      end
      #23;
      gr = array_read_en_o;
      // The rising select edge is what commits a write frame.
      cs_n = 1'b1;
      // A released data line keeps no stale level.
      si = ~si;
      #61;
   endtask

endmodule

// file: verification/tb.sv
// Self-checking bench for the select, standby and write commit block.
`timescale 1ns/1ns

module tb;
   import eswc_pkg::*;

   // A short write cycle keeps the run brief.
   localparam int unsigned WC = 200;

   logic clk, reset, sck, cs_n, si, so_o, so_oe, selected_o, standby_o;
   logic write_busy_flag, write_permit_latch, write_start_o;
   logic array_read_en_o, gr;
   logic [7:0] rx;
   int mismatches = 0;
   int checks = 0;
   int busy_len = 0;
   int starts = 0;
   logic sel_seen = 1'b0;

   // Design under test and the host on its link.
   eswc_select_ctrl #(.WRITE_CYCLES_P(WC), .CNT_W(16)) i_eswc_select_ctrl (
      .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si),
      .so_o(so_o), .so_oe(so_oe), .selected_o(selected_o),
      .standby_o(standby_o), .write_busy_flag(write_busy_flag),
      .write_permit_latch(write_permit_latch),
      .write_start_o(write_start_o), .array_read_en_o(array_read_en_o)
   );
   eswc_host_model i_eswc_host_model (
      .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
      .array_read_en_o(array_read_en_o)
   );

   // Core clock of 10 ns.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Counts commits and the length of the latest busy period.
   always @(posedge clk) begin
      if (write_start_o === 1'b1) begin
         starts++;
         busy_len = 0;
      end
      if (write_busy_flag === 1'b1) begin
         busy_len++;
      end
   end

   // Remembers whether the device ever showed itself selected.
   always @(negedge clk) begin
      if (selected_o === 1'b1) begin
         sel_seen = 1'b1;
      end
   end

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Compares one value against its expectation.
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Samples on the falling edge, well clear of the design's updates.
   task automatic settle(int n);
      repeat (n) @(negedge clk);
   endtask

   // Bounded wait for the busy flag to reach a level.
   task automatic wait_busy(logic lvl);
      int k;
      for (k = 0; k < 1000; k++) begin
         @(negedge clk);
         if (write_busy_flag === lvl) begin
            break;
         end
      end
      if (k == 1000) begin
         mismatches++;
         $display("BAD busy wait expected %b seen timeout", lvl);
         end_of_test();
      end
   endtask

   // Select held low since power-up gives no falling edge, so no effect.
   task automatic t_power_up();
      i_eswc_host_model.frame(32'h06, 8, rx, gr);
      settle(2);
      check("permit unarmed", write_permit_latch, 1'b0);
      check("standby unarmed", standby_o, 1'b1);
      check("selected unarmed", sel_seen, 1'b0);
      $display("test power_up done");
   endtask

   // Set, clear and set the permit latch, with a truncated frame between.
   task automatic t_permit();
      i_eswc_host_model.frame(32'h06, 8, rx, gr);
      settle(2);
      check("permit set", write_permit_latch, 1'b1);
      check("selected in frame", sel_seen, 1'b1);
      check("standby after frame", standby_o, 1'b1);
      check("selected after frame", selected_o, 1'b0);
      i_eswc_host_model.frame(32'h04, 8, rx, gr);
      settle(2);
      check("permit clear", write_permit_latch, 1'b0);
      // Leftover zero bits would spoil the next opcode if kept.
      i_eswc_host_model.frame(32'h00, 5, rx, gr);
      i_eswc_host_model.frame(32'h06, 8, rx, gr);
      settle(2);
      check("permit fresh frame", write_permit_latch, 1'b1);
      $display("test permit done");
   endtask

   // Status read while idle, then the output floats once deselected.
   task automatic t_status();
      i_eswc_host_model.frame(32'h0500, 16, rx, gr);
      check("status idle", rx, 8'h02);
      check("output off", so_oe, 1'b0);
      i_eswc_host_model.frame(32'h03, 8, rx, gr);
      check("read grant idle", gr, 1'b1);
      $display("test status done");
   endtask

   // A write frame cut after the address must not commit.
   task automatic t_short_write();
      i_eswc_host_model.frame(32'h020000, 24, rx, gr);
      settle(10);
      check("short write starts", starts, 0);
      check("short write busy", write_busy_flag, 1'b0);
      $display("test short_write done");
   endtask

   // Full write, traffic during the cycle, and the cycle's end.
   task automatic t_write();
      i_eswc_host_model.frame(32'h020010a5, 32, rx, gr);
      wait_busy(1'b1);
      check("commit count", starts, 1);
      check("standby in cycle", standby_o, 1'b0);
      i_eswc_host_model.frame(32'h06, 8, rx, gr);
      check("busy over select", write_busy_flag, 1'b1);
      i_eswc_host_model.frame(32'h0500, 16, rx, gr);
      check("status busy", rx, 8'h03);
      i_eswc_host_model.frame(32'h03, 8, rx, gr);
      check("read grant busy", gr, 1'b0);
      wait_busy(1'b0);
      check("busy length", busy_len, WC);
      check("permit after cycle", write_permit_latch, 1'b0);
      settle(1);
      check("standby after cycle", standby_o, 1'b1);
      check("single commit", starts, 1);
      $display("test write done");
   endtask

   // Reset, then the scenarios in order.
   initial begin
      reset = 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      settle(1);
      check("standby at reset", standby_o, 1'b1);
      t_power_up();
      t_permit();
      t_status();
      t_short_write();
      t_write();
      end_of_test();
   end

endmodule
